// >>> logic/pip_pkg.sv
// Constants, types and register map for the port interrupt sense and wake-up block.
// Assumes a single 125 MHz system clock and a plain strobe register port.
// Notes on behaviour
// - Four-bit read/write sense-invert register at 0xda; bits 3..0 serve D, C, A, B.
// - A set invert bit flips that port's trigger sense.
// - Reset clears the sense-invert register.
// - Port C triggers falling, or rising when inverted; it feeds source 0.
// - Ports B and D trigger rising when invert XOR edge-polarity bit is one.
// - Port A: falling, low level, rising, high level by invert and level-select.
// - Global enable low disables A, B, D; only reset leaves wait or stop.
// - Wait halts instructions but keeps oscillator, peripherals and state running.
// - Wake from wait resumes with no stabilisation delay.
// - Pin or watchdog reset during wait or stop starts normal reset.
// - Stop halts oscillator and execution until interrupt or reset.
// - Any watchdog active turns stop into wait.
// - Wake from stop waits an oscillator stabilisation delay first.
// - Entered from main: waking routine runs, then the following instruction.
// - Entered in non-maskable routine: continue next instruction, stay non-maskable.
// - Entered in normal routine, normal wake: continue that routine.
// - Entered in normal routine, non-maskable wake: non-maskable routine runs first.
// - Global enable low: non-maskable stays serviceable but cannot wake.
// - Wait or stop is not executed while an enabled request is pending.
// - Wake events leave the oscillator selection unchanged.
// - Global enable is bit 4 of the write-only option register.
// - Edge latch sets on edge, clears when routine starts; one edge kept.
package pip_pkg;
  localparam logic [7:0] ADDR_SENSE_INV = 8'hda;
  localparam logic [7:0] ADDR_OPTION = 8'hc8;
  localparam logic [7:0] ADDR_STAT = 8'hdb;
  localparam logic [7:0] ADDR_CTRL = 8'hdc;
  localparam int BIT_INV_B = 0;
  localparam int BIT_INV_A = 1;
  localparam int BIT_INV_C = 2;
  localparam int BIT_INV_D = 3;
  localparam int BIT_GLOBAL_EN = 4;
  localparam int BIT_EDGE_POL = 5;
  localparam int BIT_LEVEL_SEL = 6;
  localparam int BIT_OSC_SEL = 0;
  localparam logic [3:0] SENSE_INV_RESET = 4'h0;
  localparam logic [1:0] MODE_MAIN = 2'h0;
  localparam logic [1:0] MODE_IRQ = 2'h1;
  localparam logic [1:0] MODE_NMI = 2'h2;
  localparam logic [1:0] SRC_NMI = 2'h0;
  localparam logic [1:0] SRC_ONE = 2'h1;
  localparam logic [1:0] SRC_TWO = 2'h2;
  // Resume action codes handed to the sequencer
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_SERVICE = 2'h1;
  localparam logic [1:0] ACT_NEXT = 2'h2;
  localparam logic [1:0] ACT_NMI_FIRST = 2'h3;
  localparam int CLK_PERIOD_NS = 8;
  localparam int STAB_TIME_NS = 1000;
  localparam int STAB_CYCLES = (STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] STAB_LAST = 8'(STAB_CYCLES - 1);

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_WAIT = 2'b01,
    ST_STOP = 2'b10,
    ST_STAB = 2'b11
  } pip_state_t;

  // Option bits kept from the write-only option register
  typedef struct packed {
    logic level_sel;
    logic edge_pol;
    logic global_en;
  } pip_opt_t;
endpackage : pip_pkg

// >>> logic/pip_irq_wake.sv
// Port interrupt sense selection, request latches and wait/stop control.
// Assumes port pin levels, core strobes and the register port are synchronous to CLK_SYS.
`timescale 1ns/100ps
module pip_irq_wake (
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic PORT_A_IN,
  input wire logic PORT_B_IN,
  input wire logic PORT_C_IN,
  input wire logic PORT_D_IN,
  input wire logic WAIT_EXEC,
  input wire logic STOP_EXEC,
  input wire logic [1:0] CORE_MODE,
  input wire logic SVC_START,
  input wire logic [1:0] SVC_SRC,
  input wire logic WDG_HW_SEL,
  input wire logic WDG_SW_EN,
  input wire logic EXT_RST_REQ,
  input wire logic WDG_RST_REQ,
  output logic [2:0] IRQ_REQ,
  output logic CORE_HALT,
  output logic OSC_RUN,
  output logic RESUME,
  output logic [1:0] RESUME_ACT,
  output logic CORE_RST,
  output logic OSC_SEL
);
  localparam int c_stab = pip_pkg::STAB_CYCLES;

  logic rst_s1;
  logic rst_n;
  logic [3:0] sense_inv;
  pip_pkg::pip_opt_t opt;
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic [3:0] v_prev;
  logic [3:0] v_cur;
  logic lat0;
  logic lat1;
  logic lat2;
  logic [2:0] req_c;
  logic pend;
  logic wake;
  logic go_stop;
  logic rst_req;
  logic [1:0] entry_mode;
  logic [7:0] cnt;
  pip_pkg::pip_state_t state;
  pip_pkg::pip_state_t next_state;

  // Falling edge of an already-inverted level
  function automatic logic fell(input logic prev, input logic cur);
    fell = prev & ~cur;
  endfunction : fell

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // Register writes; option register is write-only
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      sense_inv <= pip_pkg::SENSE_INV_RESET;
      opt <= '0;
      OSC_SEL <= 1'b0;
    end else if (WR) begin
      if (ADDR == pip_pkg::ADDR_SENSE_INV) begin
        sense_inv <= WDATA[3:0];
      end
      if (ADDR == pip_pkg::ADDR_OPTION) begin
        opt.global_en <= WDATA[pip_pkg::BIT_GLOBAL_EN];
        opt.edge_pol <= WDATA[pip_pkg::BIT_EDGE_POL];
        opt.level_sel <= WDATA[pip_pkg::BIT_LEVEL_SEL];
      end
      // Only software moves the oscillator choice, never a wake event
      if (ADDR == pip_pkg::ADDR_CTRL) begin
        OSC_SEL <= WDATA[pip_pkg::BIT_OSC_SEL];
      end
    end
  end

  // Read data one cycle after the strobe; unmapped and write-only read zero
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      case (ADDR)
        pip_pkg::ADDR_SENSE_INV: RDATA <= {4'h0, sense_inv};
        pip_pkg::ADDR_STAT: RDATA <= {2'h0, opt.global_en, req_c, state};
        pip_pkg::ADDR_CTRL: RDATA <= {7'h00, OSC_SEL};
        default: RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end

  // Pin synchronisers; order is D, C, A, B to match invert bits
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= 4'hf;
      pin_s2 <= 4'hf;
    end else begin
      pin_s1 <= {PORT_D_IN, PORT_C_IN, PORT_A_IN, PORT_B_IN};
      pin_s2 <= pin_s1;
    end
  end

  // Sense inversion: B and D also follow the edge-polarity option
  always_comb begin
    v_cur[pip_pkg::BIT_INV_B] = pin_s2[pip_pkg::BIT_INV_B] ^ sense_inv[pip_pkg::BIT_INV_B]
                                ^ opt.edge_pol;
    v_cur[pip_pkg::BIT_INV_D] = pin_s2[pip_pkg::BIT_INV_D] ^ sense_inv[pip_pkg::BIT_INV_D]
                                ^ opt.edge_pol;
    v_cur[pip_pkg::BIT_INV_A] = pin_s2[pip_pkg::BIT_INV_A]
                                ^ sense_inv[pip_pkg::BIT_INV_A];
    v_cur[pip_pkg::BIT_INV_C] = pin_s2[pip_pkg::BIT_INV_C]
                                ^ sense_inv[pip_pkg::BIT_INV_C];
  end

  // Previous inverted level; a sense change can itself look like an edge
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      v_prev <= 4'h0;
    end else begin
      v_prev <= v_cur;
    end
  end

  // Edge latches; a new edge wins over the service clear
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      lat0 <= 1'b0;
      lat1 <= 1'b0;
      lat2 <= 1'b0;
    end else begin
      if (fell(v_prev[pip_pkg::BIT_INV_C], v_cur[pip_pkg::BIT_INV_C])) begin
        lat0 <= 1'b1;
      end else if (SVC_START && SVC_SRC == pip_pkg::SRC_NMI) begin
        lat0 <= 1'b0;
      end
      if (opt.global_en && !opt.level_sel
          && fell(v_prev[pip_pkg::BIT_INV_A], v_cur[pip_pkg::BIT_INV_A])) begin
        lat1 <= 1'b1;
      end else if (SVC_START && SVC_SRC == pip_pkg::SRC_ONE) begin
        lat1 <= 1'b0;
      end
      if (opt.global_en && (fell(v_prev[pip_pkg::BIT_INV_B], v_cur[pip_pkg::BIT_INV_B])
          || fell(v_prev[pip_pkg::BIT_INV_D], v_cur[pip_pkg::BIT_INV_D]))) begin
        lat2 <= 1'b1;
      end else if (SVC_START && SVC_SRC == pip_pkg::SRC_TWO) begin
        lat2 <= 1'b0;
      end
    end
  end

  // Requests to the core; level mode on A has no storage
  always_comb begin
    req_c[0] = lat0;
    req_c[1] = opt.global_en
               & (opt.level_sel ? ~v_cur[pip_pkg::BIT_INV_A] : lat1);
    req_c[2] = opt.global_en & lat2;
    pend = |req_c;
    wake = opt.global_en & pend;
    go_stop = STOP_EXEC & ~WDG_HW_SEL & ~WDG_SW_EN;
    rst_req = EXT_RST_REQ | WDG_RST_REQ;
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      IRQ_REQ <= 3'h0;
    end else begin
      IRQ_REQ <= req_c;
    end
  end

  // Power state sequencing
  always_comb begin
    next_state = state;
    case (state)
      pip_pkg::ST_RUN: begin
        if (!pend && go_stop) begin
          next_state = pip_pkg::ST_STOP;
        end else if (!pend && (WAIT_EXEC || STOP_EXEC)) begin
          next_state = pip_pkg::ST_WAIT;
        end
      end
      pip_pkg::ST_WAIT: begin
        if (wake) begin
          next_state = pip_pkg::ST_RUN;
        end
      end
      pip_pkg::ST_STOP: begin
        if (wake) begin
          next_state = pip_pkg::ST_STAB;
        end
      end
      pip_pkg::ST_STAB: begin
        if (cnt == 8'h00) begin
          next_state = pip_pkg::ST_RUN;
        end
      end
      default: next_state = pip_pkg::ST_RUN;
    endcase
    if (rst_req) begin
      next_state = pip_pkg::ST_RUN;
    end
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      state <= pip_pkg::ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // Stabilisation counter, loaded on the stop wake-up
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 8'h00;
    end else if (next_state == pip_pkg::ST_STAB && state == pip_pkg::ST_STOP) begin
      cnt <= pip_pkg::STAB_LAST;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end
  end

  // Core mode at entry decides how execution resumes
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      entry_mode <= pip_pkg::MODE_MAIN;
    end else if (state == pip_pkg::ST_RUN && next_state != pip_pkg::ST_RUN) begin
      entry_mode <= CORE_MODE;
    end
  end

  // Resume handshake; action fixed when leaving wait or stop
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      RESUME <= 1'b0;
      RESUME_ACT <= pip_pkg::ACT_NONE;
    end else if (state != pip_pkg::ST_RUN && next_state == pip_pkg::ST_RUN && !rst_req) begin
      RESUME <= 1'b1;
      case (entry_mode)
        pip_pkg::MODE_MAIN: RESUME_ACT <= pip_pkg::ACT_SERVICE;
        pip_pkg::MODE_NMI: RESUME_ACT <= pip_pkg::ACT_NEXT;
        pip_pkg::MODE_IRQ: begin
          RESUME_ACT <= req_c[0] ? pip_pkg::ACT_NMI_FIRST : pip_pkg::ACT_NEXT;
        end
        default: RESUME_ACT <= pip_pkg::ACT_SERVICE;
      endcase
    end else begin
      RESUME <= 1'b0;
    end
  end

  // Halt and clock outputs track the state register
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      CORE_HALT <= 1'b0;
      OSC_RUN <= 1'b1;
      CORE_RST <= 1'b0;
    end else begin
      CORE_HALT <= next_state != pip_pkg::ST_RUN;
      OSC_RUN <= next_state != pip_pkg::ST_STOP;
      CORE_RST <= rst_req;
    end
  end

  sequence s_stop_wake;
    state == pip_pkg::ST_STOP && wake && !rst_req;
  endsequence

  sequence s_stab_done;
    state == pip_pkg::ST_STAB ##1 state == pip_pkg::ST_RUN && RESUME;
  endsequence

  property p_stab_delay;
    @(posedge CLK_SYS) disable iff (!rst_n)
    s_stop_wake |-> ##c_stab s_stab_done;
  endproperty
  a_stab_delay: assert property (p_stab_delay) else $error("stop wake delay wrong");

  property p_wait_fast;
    @(posedge CLK_SYS) disable iff (!rst_n)
    state == pip_pkg::ST_WAIT && wake && !rst_req |=> RESUME && !CORE_HALT && OSC_RUN;
  endproperty
  a_wait_fast: assert property (p_wait_fast) else $error("wait wake not immediate");

  property p_wait_clock;
    @(posedge CLK_SYS) disable iff (!rst_n)
    state == pip_pkg::ST_WAIT |-> OSC_RUN && CORE_HALT;
  endproperty
  a_wait_clock: assert property (p_wait_clock) else $error("wait lost clock");

  property p_stop_clock;
    @(posedge CLK_SYS) disable iff (!rst_n)
    state == pip_pkg::ST_STOP |-> !OSC_RUN && CORE_HALT;
  endproperty
  a_stop_clock: assert property (p_stop_clock) else $error("stop kept clock");

  property p_stop_as_wait;
    @(posedge CLK_SYS) disable iff (!rst_n)
    state == pip_pkg::ST_RUN && STOP_EXEC && !pend && !rst_req && (WDG_HW_SEL || WDG_SW_EN)
      |=> state == pip_pkg::ST_WAIT;
  endproperty
  a_stop_as_wait: assert property (p_stop_as_wait) else $error("stop not turned to wait");

  property p_no_entry;
    @(posedge CLK_SYS) disable iff (!rst_n)
    state == pip_pkg::ST_RUN && (WAIT_EXEC || STOP_EXEC) && pend |=> !CORE_HALT;
  endproperty
  a_no_entry: assert property (p_no_entry) else $error("entered with request pending");

  property p_off_hold;
    @(posedge CLK_SYS) disable iff (!rst_n)
    state == pip_pkg::ST_WAIT && !opt.global_en && !rst_req |=> state == pip_pkg::ST_WAIT;
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("woke with enable low");

  property p_reset_exit;
    @(posedge CLK_SYS) disable iff (!rst_n)
    rst_req |=> CORE_RST && state == pip_pkg::ST_RUN && !RESUME;
  endproperty
  a_reset_exit: assert property (p_reset_exit) else $error("reset did not restart");

  property p_portc_edge;
    @(posedge CLK_SYS) disable iff (!rst_n)
    fell(v_prev[pip_pkg::BIT_INV_C], v_cur[pip_pkg::BIT_INV_C]) |=> lat0 ##1 IRQ_REQ[0];
  endproperty
  a_portc_edge: assert property (p_portc_edge) else $error("port c edge lost");

  property p_osc_keep;
    @(posedge CLK_SYS) disable iff (!rst_n)
    !(WR && ADDR == pip_pkg::ADDR_CTRL) |=> $stable(OSC_SEL);
  endproperty
  a_osc_keep: assert property (p_osc_keep) else $error("oscillator choice moved");

  property p_invert_read;
    @(posedge CLK_SYS) disable iff (!rst_n)
    RD && ADDR == pip_pkg::ADDR_SENSE_INV |=> RDATA == {4'h0, $past(sense_inv)};
  endproperty
  a_invert_read: assert property (p_invert_read) else $error("invert register readback");

  // Shared B and D source latches on a qualified falling inverted level of port B
  property p_srcb_latch;
    @(posedge CLK_SYS) disable iff (!rst_n)
    opt.global_en && fell(v_prev[pip_pkg::BIT_INV_B], v_cur[pip_pkg::BIT_INV_B]) |=> lat2;
  endproperty
  a_srcb_latch: assert property (p_srcb_latch) else $error("port b edge lost");

  property p_srca_level;
    @(posedge CLK_SYS) disable iff (!rst_n)
    opt.global_en && opt.level_sel && !v_cur[pip_pkg::BIT_INV_A] |=> IRQ_REQ[1];
  endproperty
  a_srca_level: assert property (p_srca_level) else $error("port a level lost");

  property p_off_quiet;
    @(posedge CLK_SYS) disable iff (!rst_n)
    !opt.global_en |=> !IRQ_REQ[1] && !IRQ_REQ[2];
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("request with enable low");

  property p_edge_clear;
    @(posedge CLK_SYS) disable iff (!rst_n)
    SVC_START && SVC_SRC == pip_pkg::SRC_NMI
      && !fell(v_prev[pip_pkg::BIT_INV_C], v_cur[pip_pkg::BIT_INV_C]) |=> !lat0;
  endproperty
  a_edge_clear: assert property (p_edge_clear) else $error("latch kept after start");
endmodule : pip_irq_wake

// >>> tb/pip_core_model.sv
// Core sequencer and port pin model facing the interrupt block.
// Assumes the bench calls its tasks from one process, after rising edges.
`timescale 1ns/100ps
module pip_core_model (
  input wire logic clk,
  output logic [3:0] pins,
  output logic svc,
  output logic [1:0] src
);
  // Pins idle high; index 0 A, 1 B, 2 C, 3 D
  initial begin
    pins = 4'hf;
    svc = 1'b0;
    src = 2'h0;
  end
  // Pin levels move just after an edge, as a synchronous source would
  task automatic pin(input int p, input logic v);
    @(posedge clk);
    pins[p] <= v;
  endtask : pin
  // One routine start; strobe dropped at the next edge so calls can chain
  task automatic serve(input logic [1:0] s);
    @(posedge clk);
    svc <= 1'b1;
    src <= s;
    @(posedge clk);
    svc <= 1'b0;
  endtask : serve
endmodule : pip_core_model

// >>> tb/pip_irq_wake_test.sv
// Self-checking bench for the port interrupt sense and wake-up block.
// Assumes the core model drives pins and routine starts; the bench drives the rest.
`timescale 1ns/100ps
module pip_irq_wake_test;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0, rd = 1'b0, wx = 1'b0, sx = 1'b0;
  logic hw = 1'b0, sw = 1'b0, er = 1'b0, wdr = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [7:0] rdata;
  logic [3:0] pins;
  logic svc, halt, osc, res, crst, osel;
  logic [1:0] src, act;
  logic [2:0] req;
  int bad_count = 0;
  int checks = 0;
  int ibit[4] = '{pip_pkg::BIT_INV_A, pip_pkg::BIT_INV_B, pip_pkg::BIT_INV_C, pip_pkg::BIT_INV_D};
  int sof[4] = '{1, 2, 0, 2};

  // 125 MHz system clock
  always #4 clk = ~clk;

  pip_irq_wake pip_irq_wake_inst (
    .CLK_SYS(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .PORT_A_IN(pins[0]), .PORT_B_IN(pins[1]), .PORT_C_IN(pins[2]),
    .PORT_D_IN(pins[3]), .WAIT_EXEC(wx), .STOP_EXEC(sx), .CORE_MODE(mode),
    .SVC_START(svc), .SVC_SRC(src), .WDG_HW_SEL(hw), .WDG_SW_EN(sw),
    .EXT_RST_REQ(er), .WDG_RST_REQ(wdr), .IRQ_REQ(req), .CORE_HALT(halt),
    .OSC_RUN(osc), .RESUME(res), .RESUME_ACT(act), .CORE_RST(crst), .OSC_SEL(osel)
  );
  pip_core_model pip_core_model_inst (.clk(clk), .pins(pins), .svc(svc), .src(src));

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  // Ends just past the edge so registered outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string m);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e, m);
  endtask : rchk
  task automatic cfg(input logic [7:0] v, input logic g, input logic b, input logic l);
    wreg(pip_pkg::ADDR_SENSE_INV, v);
    wreg(pip_pkg::ADDR_OPTION, {1'b0, l, b, g, 4'h0});
  endtask : cfg
  task automatic pin(input int p, input logic v);
    pip_core_model_inst.pin(p, v);
  endtask : pin
  // Clears every stored request, including any made by a sense change
  task automatic clr;
    for (int s = 0; s < 3; s++) begin
      pip_core_model_inst.serve(2'(s));
    end
  endtask : clr
  task automatic edge_t(input int p, input logic r, input logic e);
    pin(p, ~r);
    cyc(6);
    clr();
    cyc(2);
    pin(p, r);
    cyc(8);
    chk(8'(req[sof[p]]), 8'(e), "edge request");
  endtask : edge_t
  task automatic enter(input logic s, input logic [1:0] m);
    @(posedge clk);
    mode <= m;
    wx <= ~s;
    sx <= s;
    @(posedge clk);
    wx <= 1'b0;
    sx <= 1'b0;
    cyc(3);
  endtask : enter
  task automatic pw(input logic s, input logic [1:0] m, input int p, input logic [1:0] a,
                    input logic slow);
    int n;
    n = 0;
    enter(s, m);
    chk(8'(halt), 8'h01, "halted");
    chk(8'(osc), 8'(!slow), "oscillator");
    pin(p, 1'b0);
    while (res !== 1'b1 && n < 300) begin
      cyc(1);
      n++;
    end
    if (n == 300) begin
      bad_count++;
      summarize();
    end
    chk(8'(n > 120), 8'(slow), "wake delay");
    chk(8'(act), 8'(a), "resume action");
    chk(8'(halt), 8'h00, "running");
    chk(8'(osel), 8'h01, "osc select");
    pin(p, 1'b1);
    clr();
  endtask : pw

  initial begin
    logic t;
    logic e;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    cyc(3);
    rchk(pip_pkg::ADDR_SENSE_INV, 8'h00, "invert reset");
    wreg(pip_pkg::ADDR_SENSE_INV, 8'hff);
    rchk(pip_pkg::ADDR_SENSE_INV, 8'h0f, "invert bits");
    wreg(pip_pkg::ADDR_OPTION, 8'h70);
    rchk(pip_pkg::ADDR_OPTION, 8'h00, "option read");
    rchk(8'h00, 8'h00, "unmapped");
    $display("test registers done");
    // Every invert and edge-polarity setting in edge mode, both enable levels, every port, both edge directions
    for (int g = 0; g < 2; g++) begin
      for (int b = 0; b < 2; b++) begin
        for (int v = 0; v < 16; v++) begin
          cfg(8'(v), g[0], b[0], 1'b0);
          for (int p = 0; p < 4; p++) begin
            for (int r = 0; r < 2; r++) begin
              t = v[ibit[p]] ^ ((p == 1 || p == 3) ? b[0] : 1'b0);
              e = (g == 1 || p == 2) && (r[0] == t);
              edge_t(p, r[0], e);
            end
          end
        end
      end
    end
    $display("test edges done");
    for (int v = 0; v < 2; v++) begin
      cfg(v[0] ? 8'h02 : 8'h00, 1'b1, 1'b0, 1'b1);
      pin(0, v[0]);
      cyc(6);
      clr();
      cyc(2);
      chk(8'(req[1]), 8'h01, "level held");
      pin(0, ~v[0]);
      cyc(6);
      chk(8'(req[1]), 8'h00, "level gone");
    end
    pin(0, 1'b1);
    $display("test levels done");
    cfg(8'h00, 1'b1, 1'b0, 1'b0);
    wreg(pip_pkg::ADDR_CTRL, 8'h01);
    clr();
    rchk(pip_pkg::ADDR_CTRL, 8'h01, "control read");
    rchk(pip_pkg::ADDR_STAT, 8'h20, "status read");
    pw(1'b0, pip_pkg::MODE_MAIN, 1, pip_pkg::ACT_SERVICE, 1'b0);
    pw(1'b1, pip_pkg::MODE_MAIN, 1, pip_pkg::ACT_SERVICE, 1'b1);
    pw(1'b0, pip_pkg::MODE_NMI, 1, pip_pkg::ACT_NEXT, 1'b0);
    pw(1'b1, pip_pkg::MODE_IRQ, 3, pip_pkg::ACT_NEXT, 1'b1);
    pw(1'b0, pip_pkg::MODE_IRQ, 2, pip_pkg::ACT_NMI_FIRST, 1'b0);
    hw <= 1'b1;
    pw(1'b1, pip_pkg::MODE_MAIN, 1, pip_pkg::ACT_SERVICE, 1'b0);
    hw <= 1'b0;
    sw <= 1'b1;
    pw(1'b1, pip_pkg::MODE_MAIN, 1, pip_pkg::ACT_SERVICE, 1'b0);
    sw <= 1'b0;
    pin(1, 1'b0);
    cyc(8);
    enter(1'b0, pip_pkg::MODE_MAIN);
    chk(8'(halt), 8'h00, "entry refused");
    pin(1, 1'b1);
    clr();
    $display("test wake done");
    cfg(8'h00, 1'b0, 1'b0, 1'b0);
    for (int k = 0; k < 2; k++) begin
      enter(k[0], pip_pkg::MODE_MAIN);
      pin(2, 1'b0);
      cyc(10);
      chk(8'(halt), 8'h01, "no wake");
      @(posedge clk);
      er <= ~k[0];
      wdr <= k[0];
      cyc(2);
      chk(8'(crst), 8'h01, "reset out");
      @(posedge clk);
      er <= 1'b0;
      wdr <= 1'b0;
      cyc(3);
      chk(8'(halt), 8'h00, "restarted");
      pin(2, 1'b1);
      clr();
    end
    $display("test reset exit done");
    summarize();
  end
endmodule : pip_irq_wake_test
